// *** pcr_pkg.sv ***
package pcr_pkg;
  // Register map
  localparam logic [7:0] ADDR_PORT0   = 8'h80;
  localparam logic [7:0] ADDR_PORT2   = 8'hA0;
  localparam logic [7:0] ADDR_ROUTE0  = 8'hE1;
  localparam logic [7:0] ADDR_ROUTE1  = 8'hE2;

  // Reset values and writable masks
  localparam logic [7:0] RST_PORT0    = 8'hFF;
  localparam logic [7:0] RST_PORT2    = 8'h01;
  localparam logic [7:0] RST_ROUTE0   = 8'h00;
  localparam logic [7:0] RST_ROUTE1   = 8'h00;
  localparam logic [7:0] MASK_PORT2   = 8'h01;
  localparam logic [7:0] MASK_ROUTE0  = 8'h3F;
  localparam logic [7:0] MASK_ROUTE1  = 8'hFB;

  // Routing register 0 fields
  localparam int R0_ASYNC_SERIAL      = 0;
  localparam int R0_SYNC_SERIAL       = 1;
  localparam int R0_TWOWIRE           = 2;
  localparam int R0_SYSCLK_OUT        = 3;
  localparam int R0_CMP               = 4;
  localparam int R0_ASYNC_CMP         = 5;

  // Routing register 1 fields
  localparam int R1_COUNTER_SEL_LO    = 0;
  localparam int R1_COUNT_INPUT       = 3;
  localparam int R1_TIMER0_INPUT      = 4;
  localparam int R1_TIMER1_INPUT      = 5;
  localparam int R1_ROUTING_ENABLE    = 6;
  localparam int R1_PULLUP_DISABLE    = 7;

  // Port geometry
  localparam int NUM_PINS             = 8;
  localparam int SERIAL_TX_PIN        = 4;
  localparam int SERIAL_RX_PIN        = 5;
  localparam logic [7:0] SERIAL_PINS  = 8'h30;

  // Routed signals in priority order
  localparam int NUM_SIGS             = 15;
  typedef logic [3:0] pcr_sig_t;
  localparam pcr_sig_t SIG_SPI_SCK    = 4'h0;
  localparam pcr_sig_t SIG_SPI_MISO   = 4'h1;
  localparam pcr_sig_t SIG_SPI_MOSI   = 4'h2;
  localparam pcr_sig_t SIG_SPI_NSS    = 4'h3;
  localparam pcr_sig_t SIG_TW_DATA    = 4'h4;
  localparam pcr_sig_t SIG_TW_CLOCK   = 4'h5;
  localparam pcr_sig_t SIG_CMP        = 4'h6;
  localparam pcr_sig_t SIG_ASYNC_CMP  = 4'h7;
  localparam pcr_sig_t SIG_SYSCLK     = 4'h8;
  localparam pcr_sig_t SIG_COUNTER_MODULE0_IO       = 4'h9;
  localparam pcr_sig_t SIG_CEX1       = 4'hA;
  localparam pcr_sig_t SIG_CEX2       = 4'hB;
  localparam pcr_sig_t SIG_ECI        = 4'hC;
  localparam pcr_sig_t SIG_T0         = 4'hD;
  localparam pcr_sig_t SIG_T1         = 4'hE;
  localparam pcr_sig_t SIG_NONE       = 4'hF;
endpackage

// *** pcr_pin_cell.sv ***
`timescale 1ns/1ps
module pcr_pin_cell (
  input  wire logic clk_in,          // System clock
  input  wire logic rst_in,          // Synchronous reset
  input  wire logic routed_in,       // Pin owned by a peripheral
  input  wire logic periph_val_in,   // Peripheral output level
  input  wire logic periph_drive_in, // Peripheral wants to drive
  input  wire logic latch_in,        // Port latch bit
  input  wire logic push_pull_in,    // Output mode, 1 = push-pull
  input  wire logic force_od_in,     // Two-wire pin, always open-drain
  input  wire logic route_en_in,     // Routing enable
  input  wire logic pud_in,          // Pull-up disable
  output logic      pin_out,         // Pin output level
  output logic      pin_oe_n_out,    // Low while driving
  output logic      pullup_out       // Weak pull-up on
);
  logic val;
  logic drive_req;
  logic od;
  logic next_oe_n;

  always_comb begin
    val       = routed_in ? periph_val_in : latch_in;
    drive_req = routed_in ? periph_drive_in : 1'b1;
    od        = force_od_in | ~push_pull_in;
    // Open-drain only sinks; a high is left to the pull-up
    next_oe_n = ~(route_en_in & drive_req & (~od | ~val));
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_out      <= 1'b1;
      pin_oe_n_out <= 1'b1;
      pullup_out   <= 1'b0;
    end else begin
      pin_out      <= val;
      pin_oe_n_out <= next_oe_n;
      // Pull-up off while sinking to save power
      pullup_out   <= ~pud_in & od & next_oe_n;
    end
  end
endmodule

// *** pcr_router.sv ***
`timescale 1ns/1ps
module pcr_router (
  input  wire logic                           CLK_IN,            // System clock
  input  wire logic                           RST_IN,            // Synchronous reset
  input  wire logic [7:0]                     SFR_ADDR_IN,       // Register byte address
  input  wire logic                           SFR_WR_IN,         // Byte write strobe
  input  wire logic [7:0]                     SFR_WDATA_IN,      // Byte write data
  input  wire logic                           SFR_BIT_WR_IN,     // Single-bit write strobe
  input  wire logic [2:0]                     SFR_BIT_SEL_IN,    // Bit position
  input  wire logic                           SFR_BIT_VAL_IN,    // Bit value
  input  wire logic                           SFR_RD_IN,         // Read strobe
  input  wire logic                           SFR_RMW_IN,        // Read is part of read-modify-write
  output logic [7:0]                          SFR_RDATA_OUT,     // Read data, next cycle
  input  wire logic [pcr_pkg::NUM_PINS-1:0]   PIN_SKIP_MASK_IN,  // Pins the router passes over
  input  wire logic [pcr_pkg::NUM_PINS-1:0]   PIN_OUTPUT_MODE_IN,// 1 = push-pull
  input  wire logic [pcr_pkg::NUM_PINS-1:0]   PIN_IN,            // Port 0 pin levels
  output logic [pcr_pkg::NUM_PINS-1:0]        PIN_OUT,           // Port 0 pin drive level
  output logic [pcr_pkg::NUM_PINS-1:0]        PIN_OE_N_OUT,      // Port 0 low while driving
  output logic [pcr_pkg::NUM_PINS-1:0]        PIN_PULLUP_OUT,    // Port 0 weak pull-ups
  input  wire logic                           P2_PIN_IN,         // Port 2 pin level
  input  wire logic                           P2_PUSH_PULL_IN,   // Port 2 output mode
  output logic                                P2_PIN_OUT,        // Port 2 drive level
  output logic                                P2_OE_N_OUT,       // Port 2 low while driving
  output logic                                P2_PULLUP_OUT,     // Port 2 weak pull-up
  input  wire logic                           SERIAL_TX_LINE_IN, // Serial transmit from peripheral
  output logic                                SERIAL_RX_LINE_OUT,// Serial receive to peripheral
  input  wire logic [pcr_pkg::NUM_SIGS-1:0]   PERIPH_VAL_IN,     // Routed signal levels
  input  wire logic [pcr_pkg::NUM_SIGS-1:0]   PERIPH_DRIVE_IN,   // Routed signal drive requests
  output logic [pcr_pkg::NUM_SIGS-1:0]        PERIPH_LEVEL_OUT   // Pin level seen by each signal
);
  import pcr_pkg::*;

  logic [7:0]          port0_latch;
  logic [7:0]          port2_latch;
  logic [7:0]          routing_select_0;
  logic [7:0]          routing_select_1;
  logic                routing_enable;
  logic                pullup_disable;
  logic                async_serial_route_en;
  logic [1:0]          counter_array_route_sel;
  logic [NUM_SIGS-1:0] sig_en;
  logic [NUM_SIGS-1:0] sig_used;
  pcr_sig_t            pin_sig [NUM_PINS];
  logic [NUM_PINS-1:0] pin_routed;
  logic [NUM_PINS-1:0] pin_tw;
  logic [NUM_PINS-1:0] pin_val;
  logic [NUM_PINS-1:0] pin_drive;
  logic [NUM_PINS-1:0] taken;
  logic [7:0]          next_rdata;
  logic [NUM_SIGS-1:0] next_level;
  int                  free_cnt;
  logic                found;

  assign routing_enable          = routing_select_1[R1_ROUTING_ENABLE];
  assign pullup_disable          = routing_select_1[R1_PULLUP_DISABLE];
  assign async_serial_route_en   = routing_select_0[R0_ASYNC_SERIAL];
  assign counter_array_route_sel = routing_select_1[R1_COUNTER_SEL_LO +: 2];

  // Port latches
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      port0_latch <= RST_PORT0;
    end else if (SFR_WR_IN && SFR_ADDR_IN == ADDR_PORT0) begin
      port0_latch <= SFR_WDATA_IN;
    end else if (SFR_BIT_WR_IN && SFR_ADDR_IN == ADDR_PORT0) begin
      port0_latch[SFR_BIT_SEL_IN] <= SFR_BIT_VAL_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      port2_latch <= RST_PORT2;
    end else if (SFR_WR_IN && SFR_ADDR_IN == ADDR_PORT2) begin
      port2_latch <= SFR_WDATA_IN & MASK_PORT2;
    end else if (SFR_BIT_WR_IN && SFR_ADDR_IN == ADDR_PORT2 && SFR_BIT_SEL_IN == 3'h0) begin
      port2_latch[0] <= SFR_BIT_VAL_IN;
    end
  end

  // Routing registers are not bit addressable
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      routing_select_0 <= RST_ROUTE0;
      routing_select_1 <= RST_ROUTE1;
    end else if (SFR_WR_IN) begin
      if (SFR_ADDR_IN == ADDR_ROUTE0) begin
        routing_select_0 <= SFR_WDATA_IN & MASK_ROUTE0;
      end
      if (SFR_ADDR_IN == ADDR_ROUTE1) begin
        routing_select_1 <= SFR_WDATA_IN & MASK_ROUTE1;
      end
    end
  end

  // Read path; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    case (SFR_ADDR_IN)
      ADDR_PORT0:  next_rdata = SFR_RMW_IN ? port0_latch : PIN_IN;
      ADDR_PORT2:  next_rdata = SFR_RMW_IN ? port2_latch : {7'h00, P2_PIN_IN};
      ADDR_ROUTE0: next_rdata = routing_select_0;
      ADDR_ROUTE1: next_rdata = routing_select_1;
      default:     next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      SFR_RDATA_OUT <= 8'h00;
    end else if (SFR_RD_IN) begin
      SFR_RDATA_OUT <= next_rdata;
    end
  end

  // Signal enables in priority order
  always_comb begin
    sig_en                = '0;
    sig_en[SIG_SPI_SCK]   = routing_select_0[R0_SYNC_SERIAL];
    sig_en[SIG_SPI_MISO]  = routing_select_0[R0_SYNC_SERIAL];
    sig_en[SIG_SPI_MOSI]  = routing_select_0[R0_SYNC_SERIAL];
    sig_en[SIG_SPI_NSS]   = routing_select_0[R0_SYNC_SERIAL];
    sig_en[SIG_TW_DATA]   = routing_select_0[R0_TWOWIRE];
    sig_en[SIG_TW_CLOCK]  = routing_select_0[R0_TWOWIRE];
    sig_en[SIG_CMP]       = routing_select_0[R0_CMP];
    sig_en[SIG_ASYNC_CMP] = routing_select_0[R0_ASYNC_CMP];
    sig_en[SIG_SYSCLK]    = routing_select_0[R0_SYSCLK_OUT];
    sig_en[SIG_COUNTER_MODULE0_IO]      = counter_array_route_sel != 2'h0;
    sig_en[SIG_CEX1]      = counter_array_route_sel[1];
    sig_en[SIG_CEX2]      = counter_array_route_sel == 2'h3;
    sig_en[SIG_ECI]       = routing_select_1[R1_COUNT_INPUT];
    sig_en[SIG_T0]        = routing_select_1[R1_TIMER0_INPUT];
    sig_en[SIG_T1]        = routing_select_1[R1_TIMER1_INPUT];
  end

  // Priority decoder: walk signals, each takes the lowest free pin
  always_comb begin
    free_cnt = 0;
    found    = 1'b0;
    sig_used = '0;
    taken    = PIN_SKIP_MASK_IN | (async_serial_route_en ? SERIAL_PINS : 8'h00);
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_sig[p] = SIG_NONE;
    end
    for (int s = 0; s < NUM_SIGS; s++) begin
      if (sig_en[s]) begin
        found = 1'b0;
        // Two-wire data only proceeds if its clock also fits
        if (s == int'(SIG_TW_DATA)) begin
          free_cnt = 0;
          for (int p = 0; p < NUM_PINS; p++) begin
            if (!taken[p]) free_cnt++;
          end
        end
        if (!((s == int'(SIG_TW_DATA) && free_cnt < 2) ||
              (s == int'(SIG_TW_CLOCK) && !sig_used[SIG_TW_DATA]))) begin
          for (int p = 0; p < NUM_PINS; p++) begin
            if (!found && !taken[p]) begin
              taken[p]    = 1'b1;
              pin_sig[p]  = pcr_sig_t'(s);
              sig_used[s] = 1'b1;
              found       = 1'b1;
            end
          end
        end
      end
    end
  end

  // Pin-side mux
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_routed[p] = pin_sig[p] != SIG_NONE;
      pin_tw[p]     = pin_sig[p] == SIG_TW_DATA || pin_sig[p] == SIG_TW_CLOCK;
      pin_val[p]    = pin_routed[p] ? PERIPH_VAL_IN[pin_sig[p]] : 1'b1;
      pin_drive[p]  = pin_routed[p] ? PERIPH_DRIVE_IN[pin_sig[p]] : 1'b0;
    end
    if (async_serial_route_en) begin
      pin_routed[SERIAL_TX_PIN] = 1'b1;
      pin_val[SERIAL_TX_PIN]    = SERIAL_TX_LINE_IN;
      pin_drive[SERIAL_TX_PIN]  = 1'b1;
      pin_routed[SERIAL_RX_PIN] = 1'b1;
      pin_drive[SERIAL_RX_PIN]  = 1'b0;
    end
  end

  // Unrouted signals see an idle high
  always_comb begin
    next_level = '1;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (pin_sig[p] != SIG_NONE) begin
        next_level[pin_sig[p]] = PIN_IN[p];
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      PERIPH_LEVEL_OUT   <= '1;
      SERIAL_RX_LINE_OUT <= 1'b1;
    end else begin
      PERIPH_LEVEL_OUT   <= routing_enable ? next_level : '1;
      SERIAL_RX_LINE_OUT <= (routing_enable && async_serial_route_en) ? PIN_IN[SERIAL_RX_PIN] : 1'b1;
    end
  end

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    pcr_pin_cell u_cell (
      .clk_in          (CLK_IN),
      .rst_in          (RST_IN),
      .routed_in       (pin_routed[g]),
      .periph_val_in   (pin_val[g]),
      .periph_drive_in (pin_drive[g]),
      .latch_in        (port0_latch[g]),
      .push_pull_in    (PIN_OUTPUT_MODE_IN[g]),
      .force_od_in     (pin_tw[g]),
      .route_en_in     (routing_enable),
      .pud_in          (pullup_disable),
      .pin_out         (PIN_OUT[g]),
      .pin_oe_n_out    (PIN_OE_N_OUT[g]),
      .pullup_out      (PIN_PULLUP_OUT[g])
    );
  end

  pcr_pin_cell u_p2_cell (
    .clk_in          (CLK_IN),
    .rst_in          (RST_IN),
    .routed_in       (1'b0),
    .periph_val_in   (1'b1),
    .periph_drive_in (1'b0),
    .latch_in        (port2_latch[0]),
    .push_pull_in    (P2_PUSH_PULL_IN),
    .force_od_in     (1'b0),
    .route_en_in     (routing_enable),
    .pud_in          (pullup_disable),
    .pin_out         (P2_PIN_OUT),
    .pin_oe_n_out    (P2_OE_N_OUT),
    .pullup_out      (P2_PULLUP_OUT)
  );

  // Checks
  logic [NUM_PINS-1:0] tw_pins_q;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) tw_pins_q <= '0;
    else        tw_pins_q <= pin_tw;
  end

  property p_async_cmp;
    @(posedge CLK_IN) disable iff (RST_IN) !routing_select_0[R0_ASYNC_CMP] |-> !sig_used[SIG_ASYNC_CMP];
  endproperty
  a_async_cmp: assert property (p_async_cmp) else $error("async comparator routed while disabled");

  property p_serial_tx;
    @(posedge CLK_IN) disable iff (RST_IN)
      (routing_enable && async_serial_route_en && !SERIAL_TX_LINE_IN)
      |=> (PIN_OE_N_OUT[SERIAL_TX_PIN] == 1'b0 && PIN_OUT[SERIAL_TX_PIN] == 1'b0);
  endproperty
  a_serial_tx: assert property (p_serial_tx) else $error("serial transmit low not on pin 4");

  property p_timer_inputs;
    @(posedge CLK_IN) disable iff (RST_IN)
      (sig_used[SIG_T1] |-> routing_select_1[R1_TIMER1_INPUT]) and
      (sig_used[SIG_T0] |-> routing_select_1[R1_TIMER0_INPUT]);
  endproperty
  a_timer_inputs: assert property (p_timer_inputs) else $error("timer input routed while disabled");

  property p_count_input;
    @(posedge CLK_IN) disable iff (RST_IN) sig_used[SIG_ECI] |-> routing_select_1[R1_COUNT_INPUT];
  endproperty
  a_count_input: assert property (p_count_input) else $error("count input routed while disabled");

  property p_latch_write;
    @(posedge CLK_IN) disable iff (RST_IN)
      (SFR_WR_IN && SFR_ADDR_IN == ADDR_PORT0) |=> port0_latch == $past(SFR_WDATA_IN);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("port 0 write not latched");

  property p_pin_read;
    @(posedge CLK_IN) disable iff (RST_IN)
      (SFR_RD_IN && !SFR_RMW_IN && SFR_ADDR_IN == ADDR_PORT0) |=> SFR_RDATA_OUT == $past(PIN_IN);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("port read did not return pins");

  property p_rmw_read;
    @(posedge CLK_IN) disable iff (RST_IN)
      (SFR_RD_IN && SFR_RMW_IN && SFR_ADDR_IN == ADDR_PORT0) |=> SFR_RDATA_OUT == $past(port0_latch);
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("read-modify-write did not read latch");

  property p_bit_write;
    @(posedge CLK_IN) disable iff (RST_IN)
      (SFR_BIT_WR_IN && !SFR_WR_IN && SFR_ADDR_IN == ADDR_PORT0)
      |=> port0_latch[$past(SFR_BIT_SEL_IN)] == $past(SFR_BIT_VAL_IN);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("bit write lost");

  property p_counter_sel;
    @(posedge CLK_IN) disable iff (RST_IN)
      (counter_array_route_sel == 2'h1) |-> !sig_used[SIG_CEX1] && !sig_used[SIG_CEX2];
  endproperty
  a_counter_sel: assert property (p_counter_sel) else $error("extra counter modules routed");

  property p_reserved;
    @(posedge CLK_IN) disable iff (RST_IN) routing_select_0[7:6] == 2'h0 && routing_select_1[2] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved routing bit set");

  property p_lowest_pin;
    @(posedge CLK_IN) disable iff (RST_IN)
      (routing_select_0[R0_SYNC_SERIAL] && !PIN_SKIP_MASK_IN[0]) |-> pin_sig[0] == SIG_SPI_SCK;
  endproperty
  a_lowest_pin: assert property (p_lowest_pin) else $error("first signal not on lowest pin");

  property p_disabled_inputs;
    @(posedge CLK_IN) disable iff (RST_IN) !routing_enable |=> PIN_OE_N_OUT == '1 && P2_OE_N_OUT;
  endproperty
  a_disabled_inputs: assert property (p_disabled_inputs) else $error("driver on while routing off");

  property p_pullup;
    @(posedge CLK_IN) disable iff (RST_IN) (PIN_PULLUP_OUT & ~PIN_OE_N_OUT & ~PIN_OUT) == '0;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on while driving low");

  property p_twowire;
    @(posedge CLK_IN) disable iff (RST_IN)
      (tw_pins_q & ~PIN_OE_N_OUT & PIN_OUT) == '0 && (sig_used[SIG_TW_DATA] == sig_used[SIG_TW_CLOCK]);
  endproperty
  a_twowire: assert property (p_twowire) else $error("two-wire pin not open-drain or unpaired");

  c_serial_on:  cover property (@(posedge CLK_IN) disable iff (RST_IN) routing_enable && async_serial_route_en);
  c_all_counter: cover property (@(posedge CLK_IN) disable iff (RST_IN) sig_used[SIG_CEX2]);
  c_tw_routed:  cover property (@(posedge CLK_IN) disable iff (RST_IN) sig_used[SIG_TW_CLOCK] && routing_enable);
  c_rmw_read:   cover property (@(posedge CLK_IN) disable iff (RST_IN) SFR_RD_IN && SFR_RMW_IN);
endmodule

// *** pcr_pin_world.sv ***
`timescale 1ns/1ps
module pcr_pin_world (
  input  wire logic       clk_in,     // System clock
  input  wire logic [8:0] drv_in,     // Device drive level
  input  wire logic [8:0] oe_n_in,    // Low while device drives
  input  wire logic [8:0] pullup_in,  // Weak pull-up on
  input  wire logic [8:0] ext_en_in,  // Outside driver active
  input  wire logic [8:0] ext_val_in, // Outside driver level
  output logic      [8:0] pin_out     // Resolved pin level
);
  logic [8:0] float_pat = 9'h0AA;
  // Floating pins toggle so a stale level never passes as valid
  always_ff @(posedge clk_in) float_pat <= ~float_pat;
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      if (!oe_n_in[i]) pin_out[i] = drv_in[i];
      else if (ext_en_in[i]) pin_out[i] = ext_val_in[i];
      else if (pullup_in[i]) pin_out[i] = 1'h1;
      else pin_out[i] = float_pat[i];
    end
  end
endmodule

// *** pcr_router_tb.sv ***
`timescale 1ns/1ps
module pcr_router_tb;
  import pcr_pkg::*;
  logic        clk = 1'h0, rst = 1'h1;
  logic [7:0]  addr = 8'h00, wd = 8'h00, skip = 8'h00, mode = 8'h00;
  logic        wr = 1'h0, bwr = 1'h0, bval = 1'h0, rd = 1'h0, rmw = 1'h0, tx = 1'h1;
  logic [2:0]  bsel = 3'h0;
  logic [14:0] pval = 15'h7FFF, pdrv = 15'h0000, plvl;
  logic [8:0]  ext_en = 9'h000, ext_val = 9'h000, lvl;
  logic [7:0]  rdata, pin_o, oe_n, pu;
  logic        p2o, p2oe, p2pu, rx;
  int          n_errors = 0, num_checks = 0;
  initial forever #12.5 clk = ~clk;
  pcr_router DUT (.CLK_IN(clk), .RST_IN(rst), .SFR_ADDR_IN(addr), .SFR_WR_IN(wr), .SFR_WDATA_IN(wd),
    .SFR_BIT_WR_IN(bwr), .SFR_BIT_SEL_IN(bsel), .SFR_BIT_VAL_IN(bval), .SFR_RD_IN(rd), .SFR_RMW_IN(rmw),
    .SFR_RDATA_OUT(rdata), .PIN_SKIP_MASK_IN(skip), .PIN_OUTPUT_MODE_IN(mode), .PIN_IN(lvl[7:0]),
    .PIN_OUT(pin_o), .PIN_OE_N_OUT(oe_n), .PIN_PULLUP_OUT(pu), .P2_PIN_IN(lvl[8]), .P2_PUSH_PULL_IN(1'h0),
    .P2_PIN_OUT(p2o), .P2_OE_N_OUT(p2oe), .P2_PULLUP_OUT(p2pu), .SERIAL_TX_LINE_IN(tx),
    .SERIAL_RX_LINE_OUT(rx), .PERIPH_VAL_IN(pval), .PERIPH_DRIVE_IN(pdrv), .PERIPH_LEVEL_OUT(plvl));
  pcr_pin_world u_world (.clk_in(clk), .drv_in({p2o, pin_o}), .oe_n_in({p2oe, oe_n}),
    .pullup_in({p2pu, pu}), .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_out(lvl));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1'h1;
    cyc(1);
    wr = 1'h0;
    // Idle cycle so the next strobe never rises in this time step
    cyc(1);
  endtask
  task automatic wbit(input logic [7:0] a, input logic [2:0] s, input logic v);
    addr = a;
    bsel = s;
    bval = v;
    bwr = 1'h1;
    cyc(1);
    bwr = 1'h0;
    cyc(1);
  endtask
  task automatic rreg(input string nm, input logic [7:0] a, input logic m, input logic [7:0] exp);
    addr = a;
    rmw = m;
    rd = 1'h1;
    cyc(1);
    rd = 1'h0;
    rmw = 1'h0;
    cyc(1);
    chk(nm, exp, rdata);
  endtask
  task automatic t_reset();
    chk("oe_n", 9'h1FF, {p2oe, oe_n});
    rreg("route0", ADDR_ROUTE0, 1'h0, 8'h00);
    rreg("route1", ADDR_ROUTE1, 1'h0, 8'h00);
    rreg("port2 latch", ADDR_PORT2, 1'h1, 8'h01);
    rreg("port0 latch", ADDR_PORT0, 1'h1, 8'hFF);
    rreg("unmapped", 8'h55, 1'h0, 8'h00);
    wreg(ADDR_ROUTE0, 8'hFF);
    rreg("route0 mask", ADDR_ROUTE0, 1'h0, 8'h3F);
    wreg(ADDR_ROUTE1, 8'h04);
    rreg("route1 mask", ADDR_ROUTE1, 1'h0, 8'h00);
    wreg(ADDR_ROUTE0, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_port();
    wreg(ADDR_PORT0, 8'hA5);
    ext_en = 9'h1FF;
    ext_val = 9'h13C;
    cyc(3);
    chk("oe_n off", 9'h1FF, {p2oe, oe_n});
    rreg("port0 pins", ADDR_PORT0, 1'h0, 8'h3C);
    rreg("port0 latch", ADDR_PORT0, 1'h1, 8'hA5);
    wbit(ADDR_PORT0, 3'h1, 1'h1);
    rreg("port0 bit", ADDR_PORT0, 1'h1, 8'hA7);
    wbit(ADDR_PORT2, 3'h0, 1'h0);
    rreg("port2 latch", ADDR_PORT2, 1'h1, 8'h00);
    rreg("port2 pin", ADDR_PORT2, 1'h0, 8'h01);
    $display("test port done");
  endtask
  task automatic t_gpio();
    ext_en = 9'h000;
    mode = 8'hFF;
    wreg(ADDR_ROUTE1, 8'h40);
    wreg(ADDR_PORT0, 8'h5A);
    cyc(3);
    chk("push-pull", {8'h00, 8'h5A}, {oe_n, pin_o});
    mode = 8'h00;
    cyc(3);
    chk("open-drain", {8'h5A, 8'h5A}, {oe_n, pu});
    chk("port2 sink", 3'h0, {p2o, p2oe, p2pu});
    wreg(ADDR_ROUTE1, 8'hC0);
    cyc(3);
    chk("pullup off", 8'h00, pu);
    $display("test gpio done");
  endtask
  task automatic t_serial();
    mode = 8'hFF;
    ext_en = 9'h020;
    wreg(ADDR_ROUTE1, 8'h40);
    wreg(ADDR_ROUTE0, 8'h01);
    for (int b = 0; b < 2; b++) begin
      tx = b[0];
      // Receive level opposite to transmit, so a swapped pin shows
      ext_val = {3'h0, ~b[0], 5'h00};
      cyc(3);
      chk("serial", {b[0], 2'h2, ~b[0]}, {pin_o[4], oe_n[5:4], rx});
      rreg("port0 routed pins", ADDR_PORT0, 1'h0, {2'h1, ~b[0], b[0], 4'hA});
    end
    $display("test serial done");
  endtask
  task automatic t_prio();
    int p;
    mode = 8'h00;
    skip = 8'h01;
    ext_en = 9'h1FF;
    wreg(ADDR_PORT0, 8'hFF);
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 4; s++) begin
        wreg(ADDR_ROUTE0, {2'h0, c[0], 5'h00});
        wreg(ADDR_ROUTE1, 8'h78 | s[7:0]);
        p = 1 + c + s;
        for (int k = 0; k < 3; k++) begin
          ext_val = ~(9'h001 << (p + k));
          cyc(3);
          chk("input routing", 3'(~(3'h1 << k)), plvl[14:12]);
        end
      end
    end
    $display("test priority done");
  endtask
  task automatic t_twowire();
    mode = 8'hFF;
    skip = 8'h00;
    ext_en = 9'h000;
    pdrv = 15'h0030;
    wreg(ADDR_ROUTE1, 8'h40);
    wreg(ADDR_ROUTE0, 8'h04);
    for (int b = 0; b < 2; b++) begin
      pval[5:4] = {b[0], b[0]};
      cyc(3);
      chk("twowire", {4{b[0]}}, {oe_n[1:0], lvl[1:0]});
    end
    $display("test twowire done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    cyc(5000);
    n_errors++;
    $display("watchdog expired");
    summarize();
  end
  initial begin
    cyc(16);
    rst = 1'h0;
    t_reset();
    t_port();
    t_gpio();
    t_serial();
    t_prio();
    t_twowire();
    summarize();
  end
endmodule
